//--- rbc_pkg.sv
// Purpose: shared constants and types of the reset, boot and clock mode control
// Assumes: one 250 MHz clock, 8-bit register port
// Notes: the minimum reset low count derives from its time and the clock rate; the sequence count is fixed
package rbc_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned RST_MIN_NS = 100;
    localparam int unsigned RST_MIN_CYC = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam logic [5:0] RST_MIN_LAST = 6'(RST_MIN_CYC - 1);
    localparam logic [4:0] SEQ_CYC = 5'h10;
    localparam logic [4:0] SEQ_LAST = 5'h01;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_FBDIV = 4'h1;
    localparam logic [3:0] OFS_STAT = 4'h2;
    localparam logic [3:0] OFS_MASK = 4'h3;
    localparam logic [3:0] OFS_INFO = 4'h4;
    localparam logic [3:0] OFS_CLK = 4'h5;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CTL_EXT_OSC = 0;
    localparam int CTL_OSC_DISC = 1;
    localparam int CTL_VCO_BYP = 2;
    localparam int CTL_PD_REQ = 3;
    localparam int CTL_RAM_INIT = 4;
    localparam int ST_POR = 0;
    localparam int ST_OSC = 5;
    localparam int ST_LOCK = 6;
    localparam int ST_W = 7;
    localparam logic [6:0] STAT_RST = 7'h01;
    localparam logic [6:0] MASK_RST = 7'h00;
    localparam logic [7:0] FBDIV_RST = 8'h10;
    localparam logic [7:0] P_DIV = 8'h01;
    localparam logic [7:0] K_DIV = 8'h02;
    localparam logic [15:0] PC_START = 16'h0000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {CAUSE_POR, CAUSE_HW, CAUSE_WDOG, CAUSE_WAKE, CAUSE_BO} cause_t;
    typedef enum logic [1:0] {BOOT_USER, BOOT_LOADER, BOOT_DEBUG, BOOT_JTAG} boot_t;
    typedef enum logic [1:0] {CM_PLL, CM_PRESC, CM_BASE} clk_mode_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic boot_config_pin;
        logic tms_pin;
        logic port0_bit0_pin;
    } strap_t;

    typedef struct packed {
        clk_mode_t mode;
        logic src_vco;
        logic [7:0] mul;
        logic [7:0] div;
    } clk_cfg_t;

endpackage

//--- reset_boot_clock_mode_ctrl.sv
// Purpose: reset cause tracking, boot strap latch, regulator and clock mode control
// Assumes: srst is the power-on reset; event inputs are synchronous pulses
// Notes: register port reads answer one cycle after the strobe
//
// How it works
// - five reset causes are told apart: power-on, pin, watchdog, wake-up, brownout
// - boot straps latch at end of reset and hold until power-on or pin reset
// - only power-on or pin reset takes boot from config pin, tms and port0 bit0
// - config 1 tms 0 gives user mode, both 0 gives loader, start address zero
// - tms 1 port0 bit0 0: config 0 gives debug, config 1 gives user with jtag
// - debug mode is refused while the flash is protected
// - a watchdog timeout outside reset and power-down forces a reset recorded as its own cause
// - ram stays valid over wake, watchdog and pin resets, not power-on or brownout
// - wake-up reset turns the main regulator on; watchdog reset leaves it alone
// - active mode runs both regulators; power-down keeps only the low-power one
// - every reset selects the on-chip oscillator; software may pick the external one
// - oscillator stop and, in pll mode only, pll lock loss are flagged outside power-down
// - disconnect set gives base mode, else bypass picks prescaler or pll mode
// - base mode: system clock is free vco divided by k
// - prescaler mode: system clock is oscillator divided by p times k
// - pll mode: system clock is oscillator times n divided by p times k
// - p is fixed at 1, k at 2, only n is software selectable
`timescale 1ns/10ps
module reset_boot_clock_mode_ctrl
(
    input wire logic clk,
    input wire logic srst,
    input rbc_pkg::bus_req_t bus,
    output logic [7:0] rdata,
    input wire logic reset_pin_n,
    input rbc_pkg::strap_t strap,
    input wire logic watchdog_timeout,
    input wire logic wakeup_req,
    input wire logic brownout_det,
    input wire logic flash_protected,
    input wire logic osc_running,
    input wire logic pll_locked,
    output logic core_rst,
    output rbc_pkg::cause_t reset_cause,
    output rbc_pkg::boot_t boot_mode,
    output logic [15:0] pc_start,
    output logic ram_valid,
    output logic main_reg_en,
    output logic lp_reg_en,
    output logic power_down,
    output logic ext_osc_sel,
    output rbc_pkg::clk_cfg_t clk_cfg,
    output logic irq
);
    import rbc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic pin_s1_q;
    logic pin_s2_q;
    logic [5:0] low_cnt_q;
    logic [4:0] seq_q;
    logic core_rst_q;
    cause_t cause_q;
    boot_t boot_q;
    logic ram_valid_q;
    logic main_reg_q;
    logic pd_q;
    logic ext_osc_q;
    logic osc_disc_q;
    logic vco_byp_q;
    logic [7:0] fbdiv_q;
    logic osc_prev_q;
    logic lock_prev_q;
    logic [ST_W-1:0] stat_q;
    logic [ST_W-1:0] mask_q;
    logic [7:0] rdata_q;
    clk_cfg_t clk_cfg_q;

    // ------------------------------------------------------------
    // reset pin and event decode
    // ------------------------------------------------------------
    wire pin_low = !pin_s2_q;
    wire low_full = low_cnt_q == RST_MIN_LAST;
    wire ev_hw = pin_low && low_full;
    wire ev_bo = brownout_det;
    wire ev_wake = pd_q && wakeup_req;
    wire ev_wdog = watchdog_timeout && !core_rst_q && !pd_q;
    wire any_ev = ev_bo || ev_hw || ev_wake || ev_wdog;
    wire rel_pulse = core_rst_q && (seq_q == SEQ_LAST) && !any_ev;
    wire boot_src = (cause_q == CAUSE_POR) || (cause_q == CAUSE_HW);

    cause_t cause_d;
    assign cause_d = ev_bo ? CAUSE_BO :
                     ev_hw ? CAUSE_HW :
                     ev_wake ? CAUSE_WAKE : CAUSE_WDOG;

    // ------------------------------------------------------------
    // boot strap decode
    // ------------------------------------------------------------
    wire debug_ok = !flash_protected;
    boot_t boot_d;
    assign boot_d = !strap.tms_pin ? (strap.boot_config_pin ? BOOT_USER : BOOT_LOADER) :
                    strap.port0_bit0_pin ? BOOT_USER :
                    strap.boot_config_pin ? BOOT_JTAG :
                    debug_ok ? BOOT_DEBUG : BOOT_USER;

    // ------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------
    wire wr_ctrl = bus.wr && (bus.addr == OFS_CTRL) && !core_rst_q;
    wire wr_fbdiv = bus.wr && (bus.addr == OFS_FBDIV) && !core_rst_q;
    wire wr_mask = bus.wr && (bus.addr == OFS_MASK);
    wire rd_stat = bus.rd && (bus.addr == OFS_STAT);
    wire pd_entry = wr_ctrl && bus.wdata[CTL_PD_REQ] && !any_ev;

    // ------------------------------------------------------------
    // clock mode decode
    // ------------------------------------------------------------
    clk_mode_t cm;
    assign cm = osc_disc_q ? CM_BASE : (vco_byp_q ? CM_PRESC : CM_PLL);
    clk_cfg_t clk_cfg_d;
    assign clk_cfg_d.mode = cm;
    assign clk_cfg_d.src_vco = (cm == CM_BASE);
    assign clk_cfg_d.mul = (cm == CM_PLL) ? fbdiv_q : 8'h01;
    assign clk_cfg_d.div = (cm == CM_BASE) ? K_DIV : P_DIV * K_DIV;

    wire ev_osc = osc_prev_q && !osc_running && !pd_q;
    wire ev_lock = lock_prev_q && !pll_locked && !pd_q && (cm == CM_PLL);
    wire [ST_W-1:0] ev_vec = {ev_lock, ev_osc, ev_bo, ev_wake, ev_wdog, ev_hw, 1'b0};

    logic [7:0] rmux;
    assign rmux = (bus.addr == OFS_CTRL) ? {5'h00, vco_byp_q, osc_disc_q, ext_osc_q} :
                  (bus.addr == OFS_FBDIV) ? fbdiv_q :
                  (bus.addr == OFS_STAT) ? {1'b0, stat_q} :
                  (bus.addr == OFS_MASK) ? {1'b0, mask_q} :
                  (bus.addr == OFS_INFO) ? {main_reg_q, ram_valid_q, boot_q, 1'b0, cause_q} :
                  (bus.addr == OFS_CLK) ? {4'h0, pll_locked, osc_running, clk_cfg_q.mode} :
                  8'h00;

    // ------------------------------------------------------------
    // pin synchroniser and low-time filter
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
            low_cnt_q <= 6'h00;
        end
        else
        begin
            pin_s1_q <= reset_pin_n;
            pin_s2_q <= pin_s1_q;
            if (!pin_s2_q && !low_full)
                low_cnt_q <= low_cnt_q + 6'h01;
            else if (pin_s2_q)
                low_cnt_q <= 6'h00;
        end
    end

    // ------------------------------------------------------------
    // reset sequence and cause
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cause_q <= CAUSE_POR;
            seq_q <= SEQ_CYC;
            core_rst_q <= 1'b1;
        end
        else if (any_ev)
        begin
            cause_q <= cause_d;
            seq_q <= SEQ_CYC;
            core_rst_q <= 1'b1;
        end
        else if (core_rst_q)
        begin
            seq_q <= seq_q - 5'h01;
            core_rst_q <= !rel_pulse;
        end
    end

    // ------------------------------------------------------------
    // boot latch
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
            boot_q <= BOOT_USER;
        else if (rel_pulse && boot_src)
            boot_q <= boot_d;
    end

    // ------------------------------------------------------------
    // regulators, power-down and ram validity
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            main_reg_q <= 1'b1;
            pd_q <= 1'b0;
            ram_valid_q <= 1'b0;
        end
        else
        begin
            if (ev_wake || ev_hw || ev_bo)
                main_reg_q <= 1'b1;
            else if (pd_entry)
                main_reg_q <= 1'b0;
            if (ev_wake || ev_hw || ev_bo)
                pd_q <= 1'b0;
            else if (pd_entry)
                pd_q <= 1'b1;
            if (ev_bo)
                ram_valid_q <= 1'b0;
            else if (wr_ctrl && bus.wdata[CTL_RAM_INIT])
                ram_valid_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // clock control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst || core_rst_q)
        begin
            ext_osc_q <= 1'b0;
            osc_disc_q <= 1'b0;
            vco_byp_q <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            ext_osc_q <= bus.wdata[CTL_EXT_OSC];
            osc_disc_q <= bus.wdata[CTL_OSC_DISC];
            vco_byp_q <= bus.wdata[CTL_VCO_BYP];
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            fbdiv_q <= FBDIV_RST;
        else if (wr_fbdiv)
            fbdiv_q <= bus.wdata;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            clk_cfg_q <= '0;
            osc_prev_q <= 1'b0;
            lock_prev_q <= 1'b0;
        end
        else
        begin
            clk_cfg_q <= clk_cfg_d;
            osc_prev_q <= osc_running;
            lock_prev_q <= pll_locked;
        end
    end

    // ------------------------------------------------------------
    // status, mask and read data
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < ST_W; gi++)
        begin : g_stat
            always_ff @(posedge clk)
            begin
                if (srst)
                    stat_q[gi] <= STAT_RST[gi];
                else if (ev_vec[gi])
                    stat_q[gi] <= 1'b1;  // set wins over read clear
                else if (rd_stat)
                    stat_q[gi] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            mask_q <= MASK_RST;
            rdata_q <= 8'h00;
        end
        else
        begin
            if (wr_mask)
                mask_q <= bus.wdata[ST_W-1:0];
            rdata_q <= bus.rd ? rmux : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rdata = rdata_q;
    assign core_rst = core_rst_q;
    assign reset_cause = cause_q;
    assign boot_mode = boot_q;
    assign pc_start = PC_START;
    assign ram_valid = ram_valid_q;
    assign main_reg_en = main_reg_q;
    assign lp_reg_en = 1'b1;
    assign power_down = pd_q;
    assign ext_osc_sel = ext_osc_q;
    assign clk_cfg = clk_cfg_q;
    assign irq = |(stat_q & mask_q);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_hw_min_low: assert property (ev_hw |-> $past(pin_low, 24))
        else $error("pin reset taken before minimum low time");
    a_hw_cause: assert property (ev_hw |=> core_rst_q && cause_q == CAUSE_HW)
        else $error("pin reset not recorded");
    a_wdog_cause: assert property (ev_wdog && !ev_bo && !ev_hw |=> cause_q == CAUSE_WDOG)
        else $error("watchdog reset not recorded");
    a_boot_hold: assert property (!(rel_pulse && boot_src) |=> $stable(boot_q))
        else $error("boot mode changed outside latch point");
    a_boot_take: assert property (rel_pulse && boot_src |=> boot_q == $past(boot_d))
        else $error("boot straps not latched");
    a_boot_user: assert property (rel_pulse && boot_src && !strap.tms_pin
        |=> boot_q == ($past(strap.boot_config_pin) ? BOOT_USER : BOOT_LOADER))
        else $error("user or loader boot wrong");
    a_jtag_boot: assert property (rel_pulse && boot_src && strap.tms_pin
        && !strap.port0_bit0_pin && strap.boot_config_pin |=> boot_q == BOOT_JTAG)
        else $error("jtag user boot wrong");
    a_debug_lock: assert property (rel_pulse && flash_protected
        |=> boot_q != BOOT_DEBUG || $past(boot_q) == BOOT_DEBUG)
        else $error("debug entered with flash protected");
    a_ram_bo: assert property (ev_bo |=> !ram_valid_q)
        else $error("ram valid after brownout");
    a_ram_keep: assert property ((ev_wake || ev_wdog || ev_hw) && !ev_bo && !wr_ctrl
        |=> ram_valid_q == $past(ram_valid_q))
        else $error("ram validity lost over warm reset");
    a_wake_reg: assert property (ev_wake |=> main_reg_q && core_rst_q && !pd_q)
        else $error("wake reset left regulator off");
    a_wdog_reg: assert property (ev_wdog && !ev_hw && !ev_bo |=> main_reg_q == $past(main_reg_q))
        else $error("watchdog reset changed regulator");
    a_pd_reg: assert property (pd_entry |=> !main_reg_q && lp_reg_en && pd_q)
        else $error("power-down regulator state wrong");
    a_osc_default: assert property (core_rst_q |=> !ext_osc_q)
        else $error("external oscillator kept over reset");
    a_loss_flag: assert property (ev_osc || ev_lock |=> stat_q[ST_OSC] || stat_q[ST_LOCK])
        else $error("clock loss not flagged");
    a_base_mode: assert property (osc_disc_q |=> clk_cfg_q.mode == CM_BASE
        && clk_cfg_q.src_vco && clk_cfg_q.div == K_DIV)
        else $error("base mode selection wrong");
    a_presc_mode: assert property (!osc_disc_q && vco_byp_q |=> clk_cfg_q.mode == CM_PRESC
        && clk_cfg_q.mul == 8'h01 && clk_cfg_q.div == 8'h02)
        else $error("prescaler mode selection wrong");
    a_pll_ratio: assert property (!osc_disc_q && !vco_byp_q |=> clk_cfg_q.mul == $past(fbdiv_q)
        && clk_cfg_q.div == 8'h02)
        else $error("pll ratio wrong");

    c_hw_release: cover property (rel_pulse && cause_q == CAUSE_HW);
    c_wake: cover property (pd_q ##1 ev_wake);
    c_jtag: cover property (boot_q == BOOT_JTAG);
    c_lock_loss: cover property (ev_lock);
    c_debug_boot: cover property (rel_pulse && boot_src ##1 boot_q == BOOT_DEBUG);

endmodule

//--- board_model.sv
// Purpose: board side of the reset pin and the boot strap pins
// Assumes: pin and straps change right after a rising clock edge
// Notes: the reset pin has a pull-up, so it rests high between pulses
`timescale 1ns/10ps
module board_model
(
    input wire logic clk,
    output logic reset_pin_n,
    output rbc_pkg::strap_t strap
);
    import rbc_pkg::*;

    initial
    begin
        reset_pin_n = 1'b1;
        strap = '0;
    end

    // straps stay at the wanted levels until told otherwise
    task automatic set_straps(input strap_t s);
        @(posedge clk);
        strap <= s;
    endtask

    // low for the given count of 4 ns cycles; under 25 is too short on purpose
    task automatic pulse_reset(input int cycles);
        @(posedge clk);
        reset_pin_n <= 1'b0;
        repeat (cycles) @(posedge clk);
        reset_pin_n <= 1'b1;
    endtask
endmodule

//--- tb_reset_boot_clock_mode_ctrl.sv
// Purpose: self-checking bench of the reset, boot and clock mode control
// Assumes: 250 MHz clock, board model drives the reset pin and the straps
// Notes: random divider and mode values come from a fixed seed
`timescale 1ns/10ps
module tb_reset_boot_clock_mode_ctrl;
    import rbc_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk, srst, core_rst, ram_valid, main_reg_en, lp_reg_en, power_down, ext_osc_sel, irq, reset_pin_n;
    logic watchdog_timeout, wakeup_req, brownout_det, flash_protected, osc_running, pll_locked;
    bus_req_t bus;
    strap_t strap;
    cause_t reset_cause;
    boot_t boot_mode, last_boot;
    clk_cfg_t clk_cfg;
    logic [7:0] rdata, rd_val, fbdiv;
    logic [15:0] pc_start;
    logic [1:0] ctl;
    int mismatches, samples_checked, cycles;
    integer seed = 32'h299636c2;

    reset_boot_clock_mode_ctrl reset_boot_clock_mode_ctrl_i (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata),
        .reset_pin_n(reset_pin_n), .strap(strap), .watchdog_timeout(watchdog_timeout), .wakeup_req(wakeup_req),
        .brownout_det(brownout_det), .flash_protected(flash_protected), .osc_running(osc_running),
        .pll_locked(pll_locked), .core_rst(core_rst), .reset_cause(reset_cause), .boot_mode(boot_mode),
        .pc_start(pc_start), .ram_valid(ram_valid), .main_reg_en(main_reg_en), .lp_reg_en(lp_reg_en),
        .power_down(power_down), .ext_osc_sel(ext_osc_sel), .clk_cfg(clk_cfg), .irq(irq));
    board_model board_model_i (.clk(clk), .reset_pin_n(reset_pin_n), .strap(strap));

    initial clk = 1'b0;
    always #2 clk = ~clk;

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic give_verdict();
        if (mismatches == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string what, input logic [18:0] exp, input logic [18:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic wait_rel();
        for (int n = 0; n < 100 && core_rst !== 1'b0; n++)
        begin
            @(posedge clk);
            #1;
        end
        chk("release", 1'b0, core_rst);
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    function automatic boot_t exp_boot(input strap_t s, input logic fp);
        if (!s.tms_pin)
            return s.boot_config_pin ? BOOT_USER : BOOT_LOADER;
        if (s.port0_bit0_pin)
            return BOOT_USER;
        if (s.boot_config_pin)
            return BOOT_JTAG;
        return fp ? BOOT_USER : BOOT_DEBUG;
    endfunction

    function automatic clk_cfg_t exp_clk(input logic disc, input logic byp, input logic [7:0] n);
        if (disc)
            return '{CM_BASE, 1'b1, 8'h01, P_DIV * K_DIV};
        if (byp)
            return '{CM_PRESC, 1'b0, 8'h01, P_DIV * K_DIV};
        return '{CM_PLL, 1'b0, n, P_DIV * K_DIV};
    endfunction

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        srst = 1'b1;
        bus = '0;
        {watchdog_timeout, wakeup_req, brownout_det, flash_protected} = 4'h0;
        {osc_running, pll_locked} = 2'b11;
        {mismatches, samples_checked, cycles} = '0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        #1 chk("por cause", CAUSE_POR, reset_cause);
        chk("por ram", 1'b0, ram_valid);
        wait_rel();
        chk("por boot", exp_boot(3'h0, 1'b0), boot_mode);
        chk("pc start", 16'h0000, pc_start);
        chk("lp reg", 1'b1, lp_reg_en);
        rd(OFS_STAT, rd_val);
        chk("stat por", 8'h01, rd_val);
        rd(OFS_FBDIV, rd_val);
        chk("fbdiv reset", 8'h10, rd_val);
        rd(OFS_INFO, rd_val);
        chk("info", {2'b10, BOOT_LOADER, 1'b0, CAUSE_POR}, rd_val);
        rd(4'hf, rd_val);
        chk("unmapped", 8'h00, rd_val);
        // every strap combination, flash open and protected
        for (int i = 0; i < 16; i++)
        begin
            board_model_i.set_straps(strap_t'(i[2:0]));
            flash_protected <= i[3];
            board_model_i.pulse_reset(25);
            repeat (4) @(posedge clk);
            #1 chk("pin cause", CAUSE_HW, reset_cause);
            wait_rel();
            last_boot = exp_boot(strap_t'(i[2:0]), i[3]);
            chk("boot", last_boot, boot_mode);
        end
        rd(OFS_STAT, rd_val);
        chk("stat pin", 8'h02, rd_val);
        board_model_i.set_straps(3'h0);
        board_model_i.pulse_reset(24);
        repeat (30) @(posedge clk);
        #1 chk("short pulse", 1'b0, core_rst);
        chk("boot kept", last_boot, boot_mode);
        wr(OFS_CTRL, 8'h11);
        #1 chk("ext osc", 1'b1, ext_osc_sel);
        @(posedge clk);
        watchdog_timeout <= 1'b1;
        @(posedge clk);
        watchdog_timeout <= 1'b0;
        @(posedge clk);
        #1 chk("wdog cause", CAUSE_WDOG, reset_cause);
        wait_rel();
        chk("wdog boot", last_boot, boot_mode);
        chk("wdog ram", 1'b1, ram_valid);
        chk("wdog reg", 1'b1, main_reg_en);
        chk("osc default", 1'b0, ext_osc_sel);
        wr(OFS_CTRL, 8'h08);
        settle();
        chk("pd main reg", 1'b0, main_reg_en);
        chk("pd flag", 1'b1, power_down);
        chk("pd lp reg", 1'b1, lp_reg_en);
        @(posedge clk);
        wakeup_req <= 1'b1;
        @(posedge clk);
        wakeup_req <= 1'b0;
        @(posedge clk);
        #1 chk("wake cause", CAUSE_WAKE, reset_cause);
        chk("wake reg", 1'b1, main_reg_en);
        chk("wake pd", 1'b0, power_down);
        wait_rel();
        chk("wake ram", 1'b1, ram_valid);
        wr(OFS_CTRL, 8'h08);
        settle();
        board_model_i.pulse_reset(25);
        repeat (4) @(posedge clk);
        #1 chk("pd pin reg", 1'b1, main_reg_en);
        wait_rel();
        @(posedge clk);
        brownout_det <= 1'b1;
        @(posedge clk);
        brownout_det <= 1'b0;
        @(posedge clk);
        #1 chk("bo cause", CAUSE_BO, reset_cause);
        chk("bo ram", 1'b0, ram_valid);
        wait_rel();
        chk("bo boot", exp_boot(3'h0, 1'b1), boot_mode);
        // clock modes: all four bit pairs first, then random ones
        for (int i = 0; i < 24; i++)
        begin
            fbdiv = 8'($random(seed));
            ctl = (i < 4) ? i[1:0] : 2'($random(seed));
            wr(OFS_FBDIV, fbdiv);
            wr(OFS_CTRL, {5'h00, ctl[0], ctl[1], 1'b0});
            settle();
            chk("clk cfg", exp_clk(ctl[1], ctl[0], fbdiv), clk_cfg);
            rd(OFS_CLK, rd_val);
            chk("clk reg", {6'h03, exp_clk(ctl[1], ctl[0], fbdiv).mode}, rd_val);
        end
        wr(OFS_CTRL, 8'h00);
        rd(OFS_STAT, rd_val);
        chk("stat events", 8'h1e, rd_val);
        wr(OFS_MASK, 8'h20);
        osc_running <= 1'b0;
        settle();
        @(posedge clk);
        #1 chk("osc irq", 1'b1, irq);
        rd(OFS_STAT, rd_val);
        chk("osc loss", 8'h20, rd_val);
        osc_running <= 1'b1;
        pll_locked <= 1'b0;
        settle();
        @(posedge clk);
        #1 chk("masked irq", 1'b0, irq);
        rd(OFS_STAT, rd_val);
        chk("lock loss", 8'h40, rd_val);
        rd(OFS_MASK, rd_val);
        chk("mask", 8'h20, rd_val);
        pll_locked <= 1'b1;
        give_verdict();
    end
endmodule
